// ==== rtl/esh_pkg.sv ====
package esh_pkg;
  localparam int NAXES = 4;
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_ARG = 8'h04;
  localparam logic [7:0] ADR_CMD = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0c;
  localparam int MODE_AM_LSB = 0;
  localparam int MODE_AXIS_LSB = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;
  localparam int STAT_ECHO = 2;
  localparam int STAT_QUSE_LSB = 4;
  localparam logic [1:0] QUSE_OFS = 2'h2;
  localparam logic [15:0] TBL_MAX = 16'h0008;
  localparam logic [15:0] ENTRY_MAX = 16'h0019;
  localparam logic signed [15:0] OFS_MAX = 16'sh7f80;
  localparam logic signed [15:0] OFS_MIN = 16'sh8080;
  localparam logic signed [15:0] OFS_RST = 16'sh0000;
  // Fields {ignore, level}: home, index, phase B, phase A
  localparam logic [7:0] HOME_PAT_RST = 8'h11;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_X = 8'h58;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_N = 8'h4e;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LD = 8'h64;
  localparam logic [7:0] CH_LE = 8'h65;
  localparam logic [7:0] CH_LH = 8'h68;
  localparam logic [7:0] CH_LR = 8'h72;
  localparam logic [7:0] CH_LZ = 8'h7a;
  typedef enum logic [3:0] {OP_RAMP_ENTRY_Q, OP_RAMP_SIZE_Q, OP_OFS_SET, OP_OFS_Q, OP_ENC_STATUS, OP_ECHO_OFF,
                            OP_ECHO_ON, OP_HOME_SET, OP_HOME_Q, OP_SW_HIGH, OP_SW_LOW} esh_op_e;
  typedef enum logic [1:0] {AM_SINGLE, AM_MULTI, AM_COORD} esh_amode_e;
  typedef struct packed {logic home_sw; logic index; logic phb; logic pha;} esh_enc_s;
  typedef struct packed {logic [15:0] arg1; logic [15:0] arg0;} esh_arg_s;
endpackage : esh_pkg

// ==== rtl/esh_top.sv ====
// Contract
// - Ramp entry query: table 1 to 8, entry 1 to 25, returns that entry.
// - Entry beyond the table's breakpoints answers with a lone line feed.
// - Ramp size query, table 1 to 8, returns segment count then line feed.
// - Entry query immediate in single and multi; size query single only.
// - Offset set stores signed value, accepted from -32640 to +32640.
// - Offset defaults to zero after power up.
// - Offset set single-axis only, uses 2 queue entries, else rejected.
// - Offset query replies lower-case prefix, number, line feed.
// - Encoder status frame is 12 chars, LF CR CR at both ends.
// - Slip flag latched, cleared when its status frame is produced.
// - Encoder status immediate in single and multi, rejected in coordinated.
// - Echo disable stops echo; echo is off after every reset.
// - Home pattern carries home switch, index, phase B, phase A states.
// - Pattern value 1 true high, 0 true low, X ignored.
// - Home event only when all non-ignored signals match together.
// - Home switch defaults active low; active high also selectable.
// - Home pattern set single-axis only, on selected axis, else rejected.
// - Switch polarity selection stays effective in encoder homing.
// - Home pattern query returns prefix plus four pattern characters.
// - Default pattern: index high, A high, B low, switch low.
// - Echo enable echoes commands and sends readable error text.
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
module esh_top (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire esh_pkg::esh_enc_s [esh_pkg::NAXES-1:0] enc_i,
  input wire logic [esh_pkg::NAXES-1:0] slip_event_i,
  input wire logic [esh_pkg::NAXES-1:0] slip_en_i,
  input wire logic [esh_pkg::NAXES-1:0] maint_en_i,
  input wire logic [esh_pkg::NAXES-1:0] in_deadband_i,
  output logic [2:0] ramp_tbl_o,
  output logic [4:0] ramp_idx_o,
  input wire logic [4:0] ramp_count_i,
  input wire logic [15:0] ramp_entry_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [esh_pkg::NAXES-1:0] home_event_o,
  output logic [esh_pkg::NAXES-1:0][15:0] ofs_o,
  output logic echo_on_o,
  output logic queue_push_o,
  output logic [1:0] queue_cnt_o
);
  typedef enum {S_IDLE, S_ECHO, S_LOOK, S_LOAD, S_PRE, S_NUM, S_TAIL, S_NEXT} esh_state_e;

  function automatic logic op_ok(input logic [3:0] op, input logic [1:0] am);
    logic s;
    logic m;
    s = (am == esh_pkg::AM_SINGLE);
    m = (am == esh_pkg::AM_MULTI);
    case (op)
      esh_pkg::OP_RAMP_ENTRY_Q, esh_pkg::OP_ENC_STATUS, esh_pkg::OP_ECHO_OFF, esh_pkg::OP_ECHO_ON,
      esh_pkg::OP_HOME_Q: op_ok = s | m;
      esh_pkg::OP_RAMP_SIZE_Q, esh_pkg::OP_OFS_SET, esh_pkg::OP_OFS_Q, esh_pkg::OP_HOME_SET,
      esh_pkg::OP_SW_HIGH, esh_pkg::OP_SW_LOW: op_ok = s;
      default: op_ok = 1'b0;
    endcase
  endfunction : op_ok

  function automatic logic home_match(input logic [7:0] pat, input logic [3:0] sig);
    home_match = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (!pat[2*k+1] && (sig[k] != pat[2*k])) begin
        home_match = 1'b0;
      end
    end
  endfunction : home_match

  function automatic logic [7:0] pat_ch(input logic [1:0] f);
    pat_ch = f[1] ? esh_pkg::CH_X : (f[0] ? esh_pkg::CH_1 : esh_pkg::CH_0);
  endfunction : pat_ch

  function automatic logic [15:0] pow10(input logic [2:0] i);
    case (i)
      3'h0: pow10 = 16'h2710;
      3'h1: pow10 = 16'h03e8;
      3'h2: pow10 = 16'h0064;
      3'h3: pow10 = 16'h000a;
      default: pow10 = 16'h0001;
    endcase
  endfunction : pow10

  logic rst_q1_reg;
  logic rst_n;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_q1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1_reg <= 1'b1;
      rst_n <= rst_q1_reg;
    end
  end

  esh_state_e state_reg;
  logic [1:0] am_reg;
  logic [1:0] axis_sel_reg;
  logic [31:0] arg_reg;
  logic [3:0] op_reg;
  logic bad_reg;
  logic err_reg;
  logic echo_reg;
  logic [1:0] quse_reg;
  logic qpush_reg;
  logic multi_reg;
  logic [1:0] axis_reg;
  logic [7:0] echo_ch_reg;
  logic [2:0] tbl_reg;
  logic [4:0] idx_reg;
  logic [11:0][7:0] buf_reg;
  logic [3:0] ptr_reg;
  logic [3:0] len_reg;
  logic num_en_reg;
  logic tail_reg;
  logic [15:0] mag_reg;
  logic [2:0] dig_idx_reg;
  logic [3:0] dig_reg;
  logic started_reg;
  logic tx_valid_reg;
  logic [7:0] tx_data_reg;
  logic ack_reg;
  logic [31:0] rd_reg;
  logic [7:0] pat_reg [esh_pkg::NAXES];
  logic signed [15:0] ofs_reg [esh_pkg::NAXES];
  logic [esh_pkg::NAXES-1:0] slip_lat_reg;
  logic [esh_pkg::NAXES-1:0] match_d_reg;

  // Bus decode
  wire logic wb_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire logic wr_hit = wb_hit & wb_we_i;
  wire logic cmd_go = wr_hit & (wb_adr_i == esh_pkg::ADR_CMD) & wb_sel_i[0];
  wire logic idle = (state_reg == S_IDLE);
  wire logic acc = idle & cmd_go;
  wire logic [3:0] new_op = wb_dat_i[3:0];
  wire esh_pkg::esh_arg_s arg_s = arg_reg;
  wire logic signed [15:0] arg0_sgn = arg_s.arg0;
  wire logic tbl_ok = (arg_s.arg0 >= 16'h0001) & (arg_s.arg0 <= esh_pkg::TBL_MAX);
  wire logic ent_ok = (arg_s.arg1 >= 16'h0001) & (arg_s.arg1 <= esh_pkg::ENTRY_MAX);
  wire logic ofs_in = (arg0_sgn >= esh_pkg::OFS_MIN) & (arg0_sgn <= esh_pkg::OFS_MAX);
  wire logic rng_ok = (new_op == esh_pkg::OP_RAMP_ENTRY_Q) ? (tbl_ok & ent_ok) :
                      (new_op == esh_pkg::OP_RAMP_SIZE_Q) ? tbl_ok :
                      (new_op == esh_pkg::OP_OFS_SET) ? ofs_in : 1'b1;
  wire logic new_bad = ~op_ok(new_op, am_reg) | ~rng_ok;
  wire logic good = acc & ~new_bad;
  wire logic has_reply = (new_op == esh_pkg::OP_RAMP_ENTRY_Q) | (new_op == esh_pkg::OP_RAMP_SIZE_Q) |
                         (new_op == esh_pkg::OP_OFS_Q) | (new_op == esh_pkg::OP_ENC_STATUS) |
                         (new_op == esh_pkg::OP_HOME_Q);
  wire logic go_reply = new_bad ? echo_reg : has_reply;
  wire logic [7:0] echo_ch = (new_op < 4'ha) ? 8'(esh_pkg::CH_0 + new_op) : 8'(esh_pkg::CH_LA + new_op - 4'ha);

  // Encoder home detection and status per axis
  logic [esh_pkg::NAXES-1:0] match_w;
  genvar gi;
  generate
    for (gi = 0; gi < esh_pkg::NAXES; gi++) begin : g_axis
      assign match_w[gi] = home_match(pat_reg[gi], enc_i[gi]);
      assign ofs_o[gi] = ofs_reg[gi];
      always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          slip_lat_reg[gi] <= 1'b0;
          match_d_reg[gi] <= 1'b0;
        end else begin
          // Fresh slip wins over the clear
          slip_lat_reg[gi] <= slip_event_i[gi] |
            (slip_lat_reg[gi] & ~((state_reg == S_LOAD) & ~bad_reg & (op_reg == esh_pkg::OP_ENC_STATUS) &
            (axis_reg == gi)));
          match_d_reg[gi] <= match_w[gi];
        end
      end
    end
  endgenerate
  assign home_event_o = match_w & ~match_d_reg;

  // Reply buffer contents for the axis in hand
  wire logic [1:0] ax = axis_reg;
  wire logic [7:0] pat = pat_reg[ax];
  wire logic signed [15:0] ofs_cur = ofs_reg[ax];
  wire logic ofs_neg = ofs_cur[15];
  wire logic [15:0] ofs_mag = ofs_neg ? 16'(-ofs_cur) : ofs_cur;
  wire logic [11:0][7:0] ea_buf = {esh_pkg::CH_CR, esh_pkg::CH_CR, esh_pkg::CH_LF, esh_pkg::CH_N,
    match_w[ax] ? esh_pkg::CH_H : esh_pkg::CH_N, in_deadband_i[ax] ? esh_pkg::CH_P : esh_pkg::CH_N,
    slip_lat_reg[ax] ? esh_pkg::CH_S : esh_pkg::CH_N, maint_en_i[ax] ? esh_pkg::CH_E : esh_pkg::CH_D,
    slip_en_i[ax] ? esh_pkg::CH_E : esh_pkg::CH_D, esh_pkg::CH_CR, esh_pkg::CH_CR, esh_pkg::CH_LF};
  wire logic [11:0][7:0] eh_buf = {48'h0, pat_ch(pat[1:0]), pat_ch(pat[3:2]), pat_ch(pat[5:4]),
    pat_ch(pat[7:6]), esh_pkg::CH_LH, esh_pkg::CH_LE};
  wire logic [11:0][7:0] dz_buf = {72'h0, esh_pkg::CH_MINUS, esh_pkg::CH_LZ, esh_pkg::CH_LD};
  wire logic [11:0][7:0] err_buf = {72'h0, esh_pkg::CH_LR, esh_pkg::CH_LR, esh_pkg::CH_LE};
  wire logic beyond = {11'h0, idx_reg} > {11'h0, ramp_count_i};

  // Character output path
  wire logic can_push = ~tx_valid_reg | tx_ready_i;
  wire logic [15:0] pow = pow10(dig_idx_reg);
  wire logic dig_done = mag_reg < pow;
  wire logic emit = dig_done & ((dig_reg != 4'h0) | started_reg | (dig_idx_reg == 3'h4));
  wire logic pre_more = ptr_reg != len_reg;
  wire logic push = can_push & (((state_reg == S_ECHO) | (state_reg == S_TAIL)) |
                    ((state_reg == S_PRE) & pre_more) | ((state_reg == S_NUM) & emit));
  wire logic [7:0] push_ch = (state_reg == S_ECHO) ? echo_ch_reg :
                             (state_reg == S_TAIL) ? esh_pkg::CH_LF :
                             (state_reg == S_PRE) ? buf_reg[ptr_reg] : 8'(esh_pkg::CH_0 + dig_reg);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end else if (push) begin
      tx_valid_reg <= 1'b1;
      tx_data_reg <= push_ch;
    end else if (tx_ready_i) begin
      tx_valid_reg <= 1'b0;
    end
  end
  assign tx_valid_o = tx_valid_reg;
  assign tx_data_o = tx_data_reg;

  // Register writes and settings
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      am_reg <= esh_pkg::AM_SINGLE;
      axis_sel_reg <= 2'h0;
      arg_reg <= 32'h0;
      err_reg <= 1'b0;
      echo_reg <= 1'b0;
      quse_reg <= 2'h0;
      qpush_reg <= 1'b0;
      for (int i = 0; i < esh_pkg::NAXES; i++) begin
        pat_reg[i] <= esh_pkg::HOME_PAT_RST;
        ofs_reg[i] <= esh_pkg::OFS_RST;
      end
    end else begin
      qpush_reg <= good & (new_op == esh_pkg::OP_OFS_SET);
      if (wr_hit & (wb_adr_i == esh_pkg::ADR_MODE) & wb_sel_i[0]) begin
        am_reg <= wb_dat_i[esh_pkg::MODE_AM_LSB+:2];
        axis_sel_reg <= wb_dat_i[esh_pkg::MODE_AXIS_LSB+:2];
      end
      for (int b = 0; b < 4; b++) begin
        if (wr_hit & (wb_adr_i == esh_pkg::ADR_ARG) & wb_sel_i[b]) begin
          arg_reg[8*b+:8] <= wb_dat_i[8*b+:8];
        end
      end
      // Rejection sets the error flag; it beats a software clear
      if (acc & new_bad) begin
        err_reg <= 1'b1;
      end else if (wr_hit & (wb_adr_i == esh_pkg::ADR_STAT) & wb_sel_i[0] & wb_dat_i[esh_pkg::STAT_ERR]) begin
        err_reg <= 1'b0;
      end
      if (good) begin
        quse_reg <= (new_op == esh_pkg::OP_OFS_SET) ? esh_pkg::QUSE_OFS : 2'h0;
        case (new_op)
          esh_pkg::OP_OFS_SET: ofs_reg[axis_sel_reg] <= arg0_sgn;
          esh_pkg::OP_ECHO_OFF: echo_reg <= 1'b0;
          esh_pkg::OP_ECHO_ON: echo_reg <= 1'b1;
          esh_pkg::OP_HOME_SET: pat_reg[axis_sel_reg] <= arg_s.arg0[7:0];
          esh_pkg::OP_SW_HIGH: pat_reg[axis_sel_reg][7:6] <= 2'h1;
          esh_pkg::OP_SW_LOW: pat_reg[axis_sel_reg][7:6] <= 2'h0;
          default: ;
        endcase
      end
    end
  end
  assign echo_on_o = echo_reg;
  assign queue_push_o = qpush_reg;
  assign queue_cnt_o = quse_reg;

  // Reply sequencer
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      op_reg <= 4'h0;
      bad_reg <= 1'b0;
      multi_reg <= 1'b0;
      axis_reg <= 2'h0;
      echo_ch_reg <= 8'h00;
      tbl_reg <= 3'h0;
      idx_reg <= 5'h0;
      buf_reg <= '0;
      ptr_reg <= 4'h0;
      len_reg <= 4'h0;
      num_en_reg <= 1'b0;
      tail_reg <= 1'b0;
      mag_reg <= 16'h0;
      dig_idx_reg <= 3'h0;
      dig_reg <= 4'h0;
      started_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: if (acc) begin
          op_reg <= new_op;
          bad_reg <= new_bad;
          multi_reg <= (am_reg == esh_pkg::AM_MULTI) & (new_op == esh_pkg::OP_ENC_STATUS);
          axis_reg <= (am_reg == esh_pkg::AM_MULTI) & (new_op == esh_pkg::OP_ENC_STATUS) ? 2'h0 : axis_sel_reg;
          echo_ch_reg <= echo_ch;
          tbl_reg <= 3'(arg_s.arg0 - 16'h0001);
          idx_reg <= arg_s.arg1[4:0];
          state_reg <= echo_reg ? S_ECHO : (go_reply ? S_LOOK : S_IDLE);
        end
        S_ECHO: if (can_push) begin
          state_reg <= (bad_reg ? echo_reg : (op_reg == esh_pkg::OP_RAMP_ENTRY_Q) |
            (op_reg == esh_pkg::OP_RAMP_SIZE_Q) | (op_reg == esh_pkg::OP_OFS_Q) |
            (op_reg == esh_pkg::OP_ENC_STATUS) | (op_reg == esh_pkg::OP_HOME_Q)) ? S_LOOK : S_IDLE;
        end
        S_LOOK: state_reg <= S_LOAD;
        S_LOAD: begin
          ptr_reg <= 4'h0;
          dig_idx_reg <= 3'h0;
          dig_reg <= 4'h0;
          started_reg <= 1'b0;
          num_en_reg <= 1'b0;
          tail_reg <= 1'b1;
          len_reg <= 4'h0;
          state_reg <= S_PRE;
          if (bad_reg) begin
            buf_reg <= err_buf;
            len_reg <= 4'h3;
          end else begin
            case (op_reg)
              esh_pkg::OP_RAMP_ENTRY_Q: begin
                num_en_reg <= ~beyond;
                mag_reg <= ramp_entry_i;
              end
              esh_pkg::OP_RAMP_SIZE_Q: begin
                num_en_reg <= 1'b1;
                mag_reg <= {11'h0, ramp_count_i};
              end
              esh_pkg::OP_OFS_Q: begin
                buf_reg <= dz_buf;
                len_reg <= ofs_neg ? 4'h3 : 4'h2;
                num_en_reg <= 1'b1;
                mag_reg <= ofs_mag;
              end
              esh_pkg::OP_HOME_Q: begin
                buf_reg <= eh_buf;
                len_reg <= 4'h6;
              end
              default: begin
                buf_reg <= ea_buf;
                len_reg <= 4'hc;
                tail_reg <= 1'b0;
              end
            endcase
          end
        end
        S_PRE: if (!pre_more) begin
          state_reg <= num_en_reg ? S_NUM : (tail_reg ? S_TAIL : S_NEXT);
        end else if (can_push) begin
          ptr_reg <= ptr_reg + 4'h1;
        end
        S_NUM: if (!dig_done) begin
          mag_reg <= mag_reg - pow;
          dig_reg <= dig_reg + 4'h1;
        end else if (!emit || can_push) begin
          started_reg <= started_reg | emit;
          dig_idx_reg <= dig_idx_reg + 3'h1;
          dig_reg <= 4'h0;
          if (dig_idx_reg == 3'h4) begin
            state_reg <= S_TAIL;
          end
        end
        S_TAIL: if (can_push) begin
          state_reg <= S_NEXT;
        end
        S_NEXT: if (multi_reg && axis_reg != 2'(esh_pkg::NAXES - 1)) begin
          axis_reg <= axis_reg + 2'h1;
          state_reg <= S_LOAD;
        end else begin
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
  assign ramp_tbl_o = tbl_reg;
  assign ramp_idx_o = idx_reg;

  // Bus answer: one wait state, unmapped reads zero
  wire logic [31:0] rd_mux = (wb_adr_i == esh_pkg::ADR_MODE) ? {26'h0, axis_sel_reg, 2'h0, am_reg} :
                             (wb_adr_i == esh_pkg::ADR_ARG) ? arg_reg :
                             (wb_adr_i == esh_pkg::ADR_CMD) ? {28'h0, op_reg} :
                             (wb_adr_i == esh_pkg::ADR_STAT) ? {26'h0, quse_reg, 1'b0, echo_reg, err_reg, ~idle} :
                             32'h0;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rd_reg <= 32'h0;
    end else begin
      ack_reg <= wb_hit;
      rd_reg <= wb_hit ? rd_mux : 32'h0;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;

  a_tx_hold: assert property (@(posedge clock_i) disable iff (!rst_n)
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)) else $error("tx char dropped");
  a_multi_size_rej: assert property (@(posedge clock_i) disable iff (!rst_n)
    acc && new_op == esh_pkg::OP_RAMP_SIZE_Q && am_reg == esh_pkg::AM_MULTI |=> err_reg) else $error("size in multi");
  a_coord_ea_rej: assert property (@(posedge clock_i) disable iff (!rst_n)
    acc && new_op == esh_pkg::OP_ENC_STATUS && am_reg == esh_pkg::AM_COORD |=> err_reg && bad_reg)
    else $error("status in coord");
  a_ofs_queue: assert property (@(posedge clock_i) disable iff (!rst_n)
    good && new_op == esh_pkg::OP_OFS_SET |=> queue_push_o && queue_cnt_o == 2'h2) else $error("queue use");
  a_ofs_reject: assert property (@(posedge clock_i) disable iff (!rst_n)
    acc && new_op == esh_pkg::OP_OFS_SET && !ofs_in |=> $stable(ofs_o)) else $error("offset out of range stored");
  a_entry_lf_only: assert property (@(posedge clock_i) disable iff (!rst_n)
    state_reg == S_LOAD && !bad_reg && op_reg == esh_pkg::OP_RAMP_ENTRY_Q && beyond
    |=> !num_en_reg && len_reg == 4'h0 && tail_reg) else $error("entry beyond not bare lf");
  a_size_count: assert property (@(posedge clock_i) disable iff (!rst_n)
    state_reg == S_LOAD && !bad_reg && op_reg == esh_pkg::OP_RAMP_SIZE_Q
    |=> num_en_reg && mag_reg == {11'h0, $past(ramp_count_i)}) else $error("size value");
  a_ea_frame: assert property (@(posedge clock_i) disable iff (!rst_n)
    state_reg == S_LOAD && !bad_reg && op_reg == esh_pkg::OP_ENC_STATUS
    |=> len_reg == 4'hc && buf_reg[0] == esh_pkg::CH_LF && buf_reg[11] == esh_pkg::CH_CR && buf_reg[8] == esh_pkg::CH_N)
    else $error("status frame shape");
  a_slip_clear: assert property (@(posedge clock_i) disable iff (!rst_n)
    state_reg == S_LOAD && !bad_reg && op_reg == esh_pkg::OP_ENC_STATUS && axis_reg == 2'h0 && !slip_event_i[0]
    |=> !slip_lat_reg[0]) else $error("slip not cleared");
  a_echo_off: assert property (@(posedge clock_i) disable iff (!rst_n)
    good && new_op == esh_pkg::OP_ECHO_OFF |=> !echo_on_o ##1 !echo_on_o) else $error("echo still on");
endmodule : esh_top

// ==== verif/esh_sink.sv ====
`timescale 1ns/10ps
module esh_sink (
  input wire logic clock_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  logic [7:0] q[$];
  // Host takes characters in arrival order and stalls at random
  always @(posedge clock_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) q.push_back(tx_data_i);
    tx_ready_o <= ($urandom % 3) != 0;
  end
endmodule : esh_sink

// ==== verif/tb.sv ====
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, txv, rdy, ech, h, qp;
  logic [7:0] adr = 0, txd, p;
  logic [31:0] dat = 0, rd, dat_o;
  esh_pkg::esh_enc_s [esh_pkg::NAXES-1:0] enc = '0;
  logic [3:0] slp = 0, sen = 0, men = 0, db = 0, hev;
  logic [2:0] tbl;
  logic [4:0] cnt = 0, idx;
  logic [15:0] ent = 0;
  logic [esh_pkg::NAXES-1:0][15:0] ofs;
  logic [1:0] qc;
  int mismatches = 0, check_count = 0, cycles = 0, qpn = 0, v, t, c, a;
  int lst[3];
  string e;
  always #12.5 clk = ~clk;
  esh_top i_esh_top (.clock_i(clk), .arst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .enc_i(enc),
    .slip_event_i(slp), .slip_en_i(sen), .maint_en_i(men), .in_deadband_i(db), .ramp_tbl_o(tbl),
    .ramp_idx_o(idx), .ramp_count_i(cnt), .ramp_entry_i(ent), .tx_data_o(txd), .tx_valid_o(txv),
    .tx_ready_i(rdy), .home_event_o(hev), .ofs_o(ofs), .echo_on_o(ech), .queue_push_o(qp), .queue_cnt_o(qc));
  esh_sink i_esh_sink (.clock_i(clk), .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(rdy));
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(string n, logic [31:0] x, logic [31:0] s);
    check_count++;
    if (s !== x) begin
      mismatches++;
      $display("[ERR] %s exp %0h got %0h", n, x, s);
    end
  endtask : chk
  task automatic wb(logic w, logic [7:0] ad, logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= ad;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic mode(int ax, int m);
    wb(1, esh_pkg::ADR_MODE, 32'((ax << 4) | m));
  endtask : mode
  task automatic cmd(logic [31:0] arg, logic [3:0] op, string x);
    int n;
    n = 0;
    wb(1, esh_pkg::ADR_ARG, arg);
    wb(1, esh_pkg::ADR_CMD, {28'h0, op});
    do begin
      wb(0, esh_pkg::ADR_STAT, 0);
      n++;
    end while ((rd[esh_pkg::STAT_BUSY] !== 1'b0 || i_esh_sink.q.size() < x.len()) && n < 300);
    if (n >= 300) chk("reply wait", 0, n);
    chk("reply length", x.len(), i_esh_sink.q.size());
    for (int i = 0; i < x.len() && i < i_esh_sink.q.size(); i++) chk("reply char", x[i], i_esh_sink.q[i]);
    i_esh_sink.q.delete();
  endtask : cmd
  task automatic err(logic x);
    wb(0, esh_pkg::ADR_STAT, 0);
    chk("error flag", x, rd[esh_pkg::STAT_ERR]);
    wb(1, esh_pkg::ADR_STAT, 32'h2);
  endtask : err
  function automatic string fr(logic se, logic me, logic sl, logic d);
    return {"\n\015\015", se ? "E" : "D", me ? "E" : "D", sl ? "S" : "N", d ? "P" : "N", "NN\n\015\015"};
  endfunction : fr
  function automatic string pc(logic [1:0] f);
    return f[1] ? "X" : (f[0] ? "1" : "0");
  endfunction : pc
  always @(posedge clk) begin
    cycles++;
    if (qp === 1'b1) qpn++;
    if (cycles > 60000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    v = $urandom(79111);
    repeat (8) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    chk("offset reset", 0, |ofs);
    chk("echo reset", 0, ech);
    a = $urandom % 4;
    mode(a, 0);
    cmd(0, 4'h8, "eh0101\n");
    lst = '{32640, -32640, $urandom_range(65280) - 32640};
    for (int i = 0; i < 3; i++) begin
      cmd(lst[i], 4'h2, "");
      chk("offset", lst[i][15:0], ofs[a]);
      chk("queue use", 2, qc);
      cmd(0, 4'h3, $sformatf("dz%0d\n", lst[i]));
    end
    chk("queue pushes", 3, qpn);
    cmd(32641, 4'h2, "");
    err(1);
    mode(a, 1);
    cmd(5, 4'h2, "");
    err(1);
    chk("offset kept", lst[2][15:0], ofs[a]);
    cmd(5, 4'h1, "");
    err(1);
    {sen, men, db} <= 12'($urandom);
    p = 8'($urandom);
    slp <= p[3:0];
    @(posedge clk);
    slp <= 0;
    e = "";
    for (int i = 0; i < 4; i++) e = {e, fr(sen[i], men[i], p[i], db[i])};
    cmd(0, 4'h4, e);
    e = "";
    for (int i = 0; i < 4; i++) e = {e, fr(sen[i], men[i], 1'b0, db[i])};
    cmd(0, 4'h4, e);
    mode(a, 2);
    cmd(0, 4'h4, "");
    err(1);
    mode(a, 1);
    t = $urandom_range(8, 1);
    c = $urandom_range(24, 1);
    cnt <= 5'(c);
    v = $urandom_range(65535);
    ent <= 16'(v);
    cmd({16'(c), 16'(t)}, 4'h0, $sformatf("%0d\n", v));
    chk("table select", t - 1, tbl);
    chk("entry select", c, idx);
    cmd({16'(c + 1), 16'(t)}, 4'h0, "\n");
    mode(a, 0);
    cmd(t, 4'h1, $sformatf("%0d\n", c));
    cmd(0, 4'h6, "");
    chk("echo on", 1, ech);
    cmd(9, 4'h1, "1err\n");
    err(1);
    cmd(0, 4'h3, $sformatf("3dz%0d\n", lst[2]));
    cmd(0, 4'h5, "5");
    chk("echo off", 0, ech);
    p = 8'($urandom) & 8'h7f;
    cmd(p, 4'h7, "");
    cmd(0, 4'h8, {"eh", pc(p[7:6]), pc(p[5:4]), pc(p[3:2]), pc(p[1:0]), "\n"});
    enc[a] <= {~p[6], p[4] ^ p[5], p[2] ^ p[3], p[0] ^ p[1]};
    repeat (4) @(negedge clk);
    chk("no home", 0, hev[a]);
    @(posedge clk);
    enc[a].home_sw <= p[6];
    h = 0;
    repeat (4) @(negedge clk) h |= hev[a];
    chk("home event", 1, h);
    @(posedge clk);
    enc[a].home_sw <= 1'b0;
    e = {pc(p[5:4]), pc(p[3:2]), pc(p[1:0]), "\n"};
    cmd(0, 4'h9, "");
    cmd(0, 4'h8, {"eh1", e});
    @(posedge clk);
    enc[a].home_sw <= 1'b1;
    h = 0;
    repeat (4) @(negedge clk) h |= hev[a];
    chk("home high", 1, h);
    cmd(0, 4'ha, "");
    cmd(0, 4'h8, {"eh0", e});
    mode(a, 1);
    cmd(0, 4'h7, "");
    err(1);
    test_done();
  end
endmodule : tb
